// ### sjtap_pkg.sv
// Contract
// - full standard tap state machine and paths
// - sample inputs on rising, outputs on falling
// - tms and tdi pulled up, read high
// - tdi enters register msb
// - tdo is lsb, driven only while shifting
// - instruction selects exactly one scan register
// - five tms-high edges force reset state
// - tap reset never touches sram operation
// - power-up reset, tdo comes up hi-z
// - three-bit instruction register, shifted in shift-ir
// - idcode loaded at power-up and reset
// - capture-ir loads 01 into low bits
// - single-bit bypass register, cleared under bypass
// - new instruction takes effect at update-ir
// - idcode instruction captures 32-bit hardwired code
package sjtap_pkg;
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BSR_W = 109;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLEZ = 3'h2;
   localparam logic [2:0] INS_SAMPLE = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   localparam int BSR_OE_BIT = 108;
   localparam int RESET_TMS_EDGES = 5;
   localparam int SYNC_STAGES = 3;
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } sjtap_state_t;
endpackage

// ### sjtap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sjtap_sync
   import sjtap_pkg::*;
#(
   parameter logic INIT = 1'b1
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic din,
   output logic dout,
   output logic rise,
   output logic fall
);
   logic [SYNC_STAGES-1:0] stage;
   logic agree;
   assign agree = (stage[1] == stage[2]);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage <= {SYNC_STAGES{INIT}};
         dout <= INIT;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else
      begin
         stage <= {stage[SYNC_STAGES-2:0], din};
         // change counts only once the second and third stages agree
         dout <= agree ? stage[2] : dout;
         rise <= agree && stage[2] && !dout;
         fall <= agree && !stage[2] && dout;
      end
   end
endmodule // sjtap_sync
`default_nettype wire

// ### sjtap_tester.sv
`timescale 1ns/1ps
`default_nettype none
module sjtap_tester
(
   input wire logic clk,
   input wire logic tdo,
   input wire logic tdoOe_b,
   output logic tck,
   output logic tms,
   output logic tdi
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one tck period; tck rests low between calls, a released tdo reads inverted
   task automatic bit1(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      repeat (2) @(negedge clk);
      o = tdoOe_b ? ~tdo : tdo;
      repeat (2) @(negedge clk);
      tck = 1'b0;
   endtask
endmodule // sjtap_tester
`default_nettype wire

// ### sjtap_top.sv
`timescale 1ns/1ps
`default_nettype none
module sjtap_top
   import sjtap_pkg::*;
#(
   parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary value
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic [BSR_W-1:0] pinSample,
   output logic tdo,
   output logic tdoOe_b,
   output logic [BSR_W-1:0] bsrLatch,
   output logic extestActive,
   output logic outBusHiZ
);
   logic tmsS, tdiS, tckS, tckRise, tckFall;
   sjtap_state_t state, next_state;
   logic [IR_W-1:0] irShift, irCur;
   logic [ID_W-1:0] idShift;
   logic [BSR_W-1:0] bsrShift;
   logic bypassReg;
   // tck idle low keeps the port dormant; tms/tdi reset high as if pulled up
   sjtap_sync #(.INIT(1'b1)) uTms (.clk(clk), .rst_b(rst_b), .din(tms), .dout(tmsS),
      .rise(), .fall());
   sjtap_sync #(.INIT(1'b1)) uTdi (.clk(clk), .rst_b(rst_b), .din(tdi), .dout(tdiS),
      .rise(), .fall());
   sjtap_sync #(.INIT(1'b0)) uTck (.clk(clk), .rst_b(rst_b), .din(tck), .dout(tckS),
      .rise(tckRise), .fall(tckFall));
   // standard sixteen-state walk; five tms-high edges reach reset from anywhere
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_RESET: next_state = tmsS ? ST_RESET : ST_IDLE;
         ST_IDLE: next_state = tmsS ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = tmsS ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = tmsS ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: next_state = tmsS ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_state = tmsS ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: next_state = tmsS ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: next_state = tmsS ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_state = tmsS ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = tmsS ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: next_state = tmsS ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: next_state = tmsS ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_state = tmsS ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: next_state = tmsS ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: next_state = tmsS ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_state = tmsS ? ST_SEL_DR : ST_IDLE;
      endcase
   end
   wire selId = (irCur == INS_IDCODE);
   wire selBsr = (irCur == INS_EXTEST) || (irCur == INS_SAMPLE) || (irCur == INS_SAMPLEZ);
   // reserved codes fall to bypass so the chain never breaks
   wire selByp = !selId && !selBsr;
   wire capDr = (state == ST_CAP_DR);
   wire shDr = (state == ST_SH_DR);
   wire updDr = (state == ST_UPD_DR);
   wire shIr = (state == ST_SH_IR);
   wire shifting = shDr || shIr;
   wire serialOut = shIr ? irShift[0] : selId ? idShift[0] : selBsr ? bsrShift[0] :
      bypassReg;
   // everything here is on the test clock only; sram paths are untouched
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= ST_RESET;
         irCur <= INS_IDCODE;
         irShift <= INS_IDCODE;
      end
      else if (tckRise)
      begin
         state <= next_state;
         // act on entry so the fall inside reset or update already sees the new code
         if (next_state == ST_RESET)
            irCur <= INS_IDCODE;
         else if (next_state == ST_UPD_IR)
            irCur <= irShift;
         if (state == ST_CAP_IR)
            irShift <= {irShift[IR_W-1:2], IR_CAPTURE};
         else if (shIr)
            irShift <= {tdiS, irShift[IR_W-1:1]};
      end
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         idShift <= '0;
         bsrShift <= '0;
         bypassReg <= 1'b0;
      end
      else if (tckRise && selId && (capDr || shDr))
         idShift <= capDr ? ID_CODE : {tdiS, idShift[ID_W-1:1]};
      else if (tckRise && selBsr && (capDr || shDr))
         bsrShift <= capDr ? pinSample : {tdiS, bsrShift[BSR_W-1:1]};
      else if (tckRise && selByp && (capDr || shDr))
         bypassReg <= capDr ? 1'b0 : tdiS;
   end
   // bus control follows the latch value written on the same fall, not the stale one
   wire [BSR_W-1:0] next_bsrLatch = (state == ST_RESET) ? '0 :
      (updDr && selBsr) ? bsrShift : bsrLatch;
   // latches and tdo move on the tck falling edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tdo <= 1'b1;
         tdoOe_b <= 1'b1;
         bsrLatch <= '0;
         extestActive <= 1'b0;
         outBusHiZ <= 1'b0;
      end
      else if (tckFall)
      begin
         tdo <= serialOut;
         tdoOe_b <= !shifting;
         bsrLatch <= next_bsrLatch;
         extestActive <= (irCur == INS_EXTEST);
         // the oe cell idles low, which under extest floats the q-bus
         outBusHiZ <= (irCur == INS_SAMPLEZ) ||
            ((irCur == INS_EXTEST) && !next_bsrLatch[BSR_OE_BIT]);
      end
   end
endmodule // sjtap_top
`default_nettype wire

// ### sjtap_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sjtap_top_chk
   import sjtap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdoOe_b,
   input wire logic [BSR_W-1:0] bsrLatch,
   input wire logic extestActive,
   input wire logic outBusHiZ
);
   logic [2:0] tq;
   logic [2:0] hi;
   logic lastTms;
   // three flops and no agree check, so lastTms settles before the design acts on the same edge
   wire logic tckUp = tq[1] & ~tq[2];
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         tq <= 3'h0;
         hi <= 3'h0;
         lastTms <= 1'b1;
      end
      else
      begin
         tq <= {tq[1:0], tck};
         if (tckUp)
         begin
            lastTms <= tms;
            hi <= tms ? hi + 3'h1 : 3'h0;
         end
      end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_tdo_fall: assert property (
      ($changed(tdo) || $changed(tdoOe_b)) |-> !$past(tck, 2)) else $error("tdo moved off tck low");
   a_powerup_hiz: assert property ($rose(rst_b) |-> tdoOe_b)
      else $error("tdo driven at reset");
   a_tms_reset: assert property (
      hi == 3'h5 |-> ##8 (tdoOe_b && !extestActive && !outBusHiZ && bsrLatch == '0))
      else $error("no reset after tms high");
   a_shift_entry: assert property ($fell(tdoOe_b) |-> !lastTms)
      else $error("bad oe on");
   a_shift_exit: assert property ($rose(tdoOe_b) |-> lastTms)
      else $error("bad oe off");
   a_bus_hiz: assert property (
      extestActive && $past(extestActive) && $stable(bsrLatch) |-> outBusHiZ != bsrLatch[BSR_OE_BIT])
      else $error("bus control wrong");
   a_ir_update: assert property ($changed(extestActive) |-> lastTms)
      else $error("ir early");
   a_latch_update: assert property ($changed(bsrLatch) |-> lastTms)
      else $error("latch early");
endmodule // sjtap_top_chk
bind sjtap_top sjtap_top_chk chk (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdo(tdo),
   .tdoOe_b(tdoOe_b), .bsrLatch(bsrLatch), .extestActive(extestActive), .outBusHiZ(outBusHiZ));
`default_nettype wire

// ### tb_sjtap_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sjtap_top;
   import sjtap_pkg::*;
   localparam logic [31:0] ID = 32'h5a3c_0e01; // arbitrary value
   logic clk, rst_b, tck, tms, tdi, tdo, tdoOe_b, extestActive, outBusHiZ, b;
   logic [BSR_W-1:0] pinSample, bsrLatch;
   logic [127:0] res, e, d, q[$];
   logic [2:0] codes[4] = '{3'h7, 3'h3, 3'h5, 3'h6};
   int bad_count = 0, checks_done = 0, cyc = 0;
   event done;
   sjtap_top #(.ID_CODE(ID)) dut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
      .pinSample(pinSample), .tdo(tdo), .tdoOe_b(tdoOe_b), .bsrLatch(bsrLatch),
      .extestActive(extestActive), .outBusHiZ(outBusHiZ));
   sjtap_tester tp (.clk(clk), .tdo(tdo), .tdoOe_b(tdoOe_b), .tck(tck), .tms(tms), .tdi(tdi));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic note(input logic [127:0] got, input logic [127:0] exp);
      q.push_back(exp);
      res = got;
      -> done;
      #1;
   endtask
   // from idle; ir msb capture is left open, so only the low two bits count
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
      input logic [127:0] exp);
      logic [127:0] r = '0;
      tp.bit1(1'b1, 1'b1, b);
      if (ir)
         tp.bit1(1'b1, 1'b1, b);
      repeat (2) tp.bit1(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++)
         tp.bit1(i == n - 1, din[i], r[i]);
      tp.bit1(1'b1, 1'b1, b);
      tp.bit1(1'b0, 1'b1, b);
      note(ir ? r & 128'h3 : r, exp);
   endtask
   always @(done)
   begin
      e = q.pop_front();
      checks_done++;
      if (res !== e)
      begin
         $display("CHECK FAILED %0t got %h exp %h", $time, res, e);
         bad_count++;
      end
   end
   always @(posedge clk)
      if (++cyc == 8000)
      begin
         bad_count++;
         tally_and_finish;
      end
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      rst_b = 1'b0;
      void'($urandom(32'h96bb));
      d = {$urandom, $urandom, $urandom, $urandom};
      pinSample = d[BSR_W-1:0];
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      note(128'(tdoOe_b), 128'h1);
      repeat (8) @(negedge clk);
      tp.bit1(1'b0, 1'b1, b);
      scan(1'b0, ID_W, d, 128'(ID));
      foreach (codes[i])
      begin
         scan(1'b1, IR_W, 128'(codes[i]), 128'h1);
         d = 128'($urandom);
         scan(1'b0, 8, d, 128'({d[6:0], 1'b0}));
      end
      scan(1'b1, IR_W, 128'(INS_SAMPLE), 128'h1);
      d = {$urandom, $urandom, $urandom, $urandom} >> 19;
      d[BSR_OE_BIT] = 1'b0;
      scan(1'b0, BSR_W, d, 128'(pinSample));
      note(128'(bsrLatch), d);
      scan(1'b1, IR_W, 128'(INS_SAMPLEZ), 128'h1);
      note(128'({extestActive, outBusHiZ}), 128'h1);
      scan(1'b1, IR_W, 128'(INS_EXTEST), 128'h1);
      note(128'({extestActive, outBusHiZ}), 128'h3);
      tp.bit1(1'b1, 1'b1, b);
      repeat (2) tp.bit1(1'b0, 1'b1, b);
      repeat (5) tp.bit1(1'b1, 1'b1, b);
      repeat (8) @(negedge clk);
      note(128'({extestActive, outBusHiZ, tdoOe_b}), 128'h1);
      tp.bit1(1'b0, 1'b1, b);
      scan(1'b0, ID_W, d, 128'(ID));
      tally_and_finish;
   end
endmodule // tb_sjtap_top
`default_nettype wire
